// ---- verilog/rbc_defines.svh ----
// register offsets, field positions, reset values and timing counts
// assumes a 32-bit apb slave with byte addresses on an 8-bit paddr
`ifndef RBC_DEFINES_SVH
`define RBC_DEFINES_SVH

// register byte offsets
`define RBC_SYSCTL_OFF 8'h00
`define RBC_STAT_OFF 8'h04
`define RBC_COMMAND_STATUS_REGISTER_OFF 8'h08
`define RBC_ISTAT_OFF 8'h0c
`define RBC_IMASK_OFF 8'h10

// system control field positions
`define RBC_SOFTWARE_RESET_BIT 15
`define RBC_DISPLAY_RESET_BIT 14
`define RBC_DEN_BIT 13
`define RBC_RENDERING_BREAK_REQUEST_BIT 10
`define RBC_DC_BIT 9
`define RBC_RS_BIT 8
`define RBC_DBM_LO 6
`define RBC_DBM_HI 7

// status flag positions
`define RBC_ST_TRAP 0
`define RBC_ST_BRK 1
`define RBC_ST_CER 2
`define RBC_ST_CSF 3
`define RBC_ST_BUSY 4
`define RBC_ST_FLUSH 5

// interrupt bit positions and width
`define RBC_IRQ_TRAP 0
`define RBC_IRQ_BRK 1
`define RBC_IRQ_SWAP 2
`define RBC_IRQ_START 3
`define RBC_IRQ_CER 4
`define RBC_IRQ_W 5

// reset values
`define RBC_DISPLAY_RESET_RST 1'b1
`define RBC_DBM_RST 2'b00

// timing: idle time before an automatic fifo drain
`define RBC_PCLK_NS 50
`define RBC_BASE_PERIOD_NS 50
`define RBC_IDLE_TCYC 32
`define RBC_IDLE_CYC ((`RBC_IDLE_TCYC * `RBC_BASE_PERIOD_NS + `RBC_PCLK_NS - 1) / `RBC_PCLK_NS)

`endif

// ---- verilog/rbc_pkg.sv ----
// types shared by the rendering break and buffer control block
// assumes rbc_defines.svh is on the include path
package rbc_pkg;
	`include "rbc_defines.svh"

	// double-buffer control modes
	typedef enum logic [1:0] {
		RBC_DBM_AUTO_DISP = 2'b00,
		RBC_DBM_AUTO_REND = 2'b01,
		RBC_DBM_MANUAL = 2'b10,
		RBC_DBM_BAD = 2'b11
	} rbc_dbm_e;

	// idle counter state
	typedef struct packed {
		logic [5:0] cnt;
		logic hit;
	} rbc_idle_s;

	// main block state
	typedef struct packed {
		logic rendering_break_request;
		logic display_area_change;
		logic rendering_start;
		rbc_dbm_e dbm;
		logic display_reset;
		logic display_enable;
		logic trap_flag;
		logic drawing_break_flag;
		logic cmd_error;
		logic cmd_suspend;
		logic [31:0] command_status_register;
		logic flush;
		logic [`RBC_IRQ_W-1:0] istat;
		logic [`RBC_IRQ_W-1:0] imask;
		logic irq;
		logic start_p;
		logic term_p;
		logic swap_p;
		logic ready;
		logic slverr;
		logic [31:0] rdata;
	} rbc_state_s;
endpackage : rbc_pkg

// ---- verilog/rbc_idle_cnt.sv ----
// idle watch on host graphics memory accesses
// assumes the access strobe is on pclk; base clock equals pclk
`timescale 1ns/1ps
`include "rbc_defines.svh"
module rbc_idle_cnt (
	input logic pclk, // system clock
	input logic presetn, // async reset, active low
	input logic access, // host touched graphics memory this cycle
	output logic hit // one pulse after the idle time
);
	import rbc_pkg::*;

	localparam logic [5:0] IDLE_CYC = 6'(`RBC_IDLE_CYC);

	rbc_idle_s r_reg;
	rbc_idle_s r_next;

	// count idle cycles, saturate so the pulse fires once per gap
	always_comb begin
		r_next = r_reg;
		r_next.hit = 1'b0;
		if (access) begin
			r_next.cnt = 6'h00;
		end else if (r_reg.cnt != IDLE_CYC) begin
			r_next.cnt = r_reg.cnt + 6'h01;
			r_next.hit = (r_reg.cnt == IDLE_CYC - 6'h01);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign hit = r_reg.hit;
endmodule : rbc_idle_cnt

// ---- verilog/rbc_top.sv ----
// rendering break, rendering start, fifo drain and buffer switch control
// assumes the rendering engine and display unit run on pclk
// Notes on behaviour
// - trap command sets trap flag, ends drawing
// - break request ends drawing at next command fetch
// - break request while idle leaves break flag
// - after break, command status holds next address
// - break request cleared only by actual break; here software reset also clears it
// - manual mode: display change bit requests swap
// - display change write of one needs bit clear
// - swap on frames, or fields in sync video
// - display change bit cleared after swap done
// - rendering start bit starts, then self-clears
// - rendering start first drains host write fifo
// - drain fifo after 32 idle base cycles
// - mode 00 auto, 01 render, 10 manual
// - refresh-only display mode blocks rendering start
// - software reset clears error, trap, break flags
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "rbc_defines.svh"
module rbc_top (
	input logic pclk, // system clock
	input logic presetn, // async reset, active low
	input logic psel, // apb select
	input logic penable, // apb access phase
	input logic pwrite, // apb write
	input logic [7:0] paddr, // apb byte address
	input logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input logic drawing_active, // engine is drawing
	input logic cmd_fetch, // engine fetches a command
	input logic [31:0] cmd_fetch_addr, // start address of fetched command
	input logic trap_exec, // trap command executed
	input logic cmd_error_ev, // engine command error
	input logic cmd_suspend_ev, // engine command suspended
	input logic frame_start, // display frame boundary
	input logic field_start, // display field boundary
	input logic ilace_sync_video, // display in interlace sync and video
	input logic host_gm_access, // host touched graphics memory
	input logic host_gm_read, // host read graphics memory
	input logic fifo_empty, // host write fifo is empty
	output logic fifo_flush, // drain host write fifo to memory
	output logic render_start, // one pulse: start drawing
	output logic draw_terminate, // one pulse: drawing ended
	output logic buffer_switch, // one pulse: swap display buffer
	output rbc_pkg::rbc_dbm_e dbm_mode, // double-buffer mode
	output logic display_reset, // display reset control
	output logic display_enable, // display enable control
	output logic irq // level interrupt
);
	import rbc_pkg::*;

	rbc_state_s r_reg;
	rbc_state_s r_next;

	logic idle_hit;
	logic access_done;
	logic sys_wr;
	logic software_reset_wr;
	logic refresh_only;
	logic brk_take;
	logic swap_take;
	logic start_take;

	// drains after a quiet gap on the host memory port
	rbc_idle_cnt u_idle (
		.pclk(pclk),
		.presetn(presetn),
		.access(host_gm_access),
		.hit(idle_hit)
	);

	// event decode shared by next state and checks
	always_comb begin
		access_done = psel & penable & r_reg.ready;
		sys_wr = access_done & pwrite & (paddr == `RBC_SYSCTL_OFF);
		software_reset_wr = sys_wr & pwdata[`RBC_SOFTWARE_RESET_BIT];
		refresh_only = r_reg.display_reset & ~r_reg.display_enable;
		brk_take = cmd_fetch & drawing_active & r_reg.rendering_break_request;
		swap_take = r_reg.display_area_change & (r_reg.dbm == RBC_DBM_MANUAL) &
			(ilace_sync_video ? field_start : frame_start);
		// wait for the drain so rendering never sees stale memory
		start_take = r_reg.rendering_start & fifo_empty & ~r_reg.flush &
			~refresh_only & ~drawing_active & ~r_reg.start_p;
	end

	// next state: hardware clears first, then sets, so sets win
	always_comb begin
		logic [31:0] rd_val;
		rd_val = 32'h0000_0000;
		r_next = r_reg;
		r_next.start_p = 1'b0;
		r_next.term_p = 1'b0;
		r_next.swap_p = 1'b0;
		r_next.slverr = 1'b0;
		// two-cycle access phase keeps prdata coming from a flop
		r_next.ready = psel & penable & ~r_reg.ready;

		// read mux shows live bits, hardware clears included
		unique case (paddr)
			`RBC_SYSCTL_OFF: begin
				rd_val[`RBC_DISPLAY_RESET_BIT] = r_reg.display_reset;
				rd_val[`RBC_DEN_BIT] = r_reg.display_enable;
				rd_val[`RBC_RENDERING_BREAK_REQUEST_BIT] = r_reg.rendering_break_request;
				rd_val[`RBC_DC_BIT] = r_reg.display_area_change;
				rd_val[`RBC_RS_BIT] = r_reg.rendering_start;
				rd_val[`RBC_DBM_HI:`RBC_DBM_LO] = r_reg.dbm;
			end
			`RBC_STAT_OFF: begin
				rd_val[`RBC_ST_TRAP] = r_reg.trap_flag;
				rd_val[`RBC_ST_BRK] = r_reg.drawing_break_flag;
				rd_val[`RBC_ST_CER] = r_reg.cmd_error;
				rd_val[`RBC_ST_CSF] = r_reg.cmd_suspend;
				rd_val[`RBC_ST_BUSY] = drawing_active;
				rd_val[`RBC_ST_FLUSH] = r_reg.flush;
			end
			`RBC_COMMAND_STATUS_REGISTER_OFF: rd_val = r_reg.command_status_register;
			`RBC_ISTAT_OFF: rd_val[`RBC_IRQ_W-1:0] = r_reg.istat;
			`RBC_IMASK_OFF: rd_val[`RBC_IRQ_W-1:0] = r_reg.imask;
			default: rd_val = 32'h0000_0000;
		endcase
		if (psel & penable & ~r_reg.ready) begin
			r_next.rdata = rd_val;
			r_next.slverr = ~(paddr == `RBC_SYSCTL_OFF || paddr == `RBC_STAT_OFF ||
				paddr == `RBC_COMMAND_STATUS_REGISTER_OFF || paddr == `RBC_ISTAT_OFF ||
				paddr == `RBC_IMASK_OFF);
		end

		// software reset clears the engine flags and break request
		if (software_reset_wr) begin
			r_next.cmd_error = 1'b0;
			r_next.trap_flag = 1'b0;
			r_next.cmd_suspend = 1'b0;
			r_next.rendering_break_request = 1'b0;
			r_next.drawing_break_flag = 1'b0;
		end

		// hardware clears of the control bits
		if (brk_take) begin
			r_next.rendering_break_request = 1'b0;
		end
		if (swap_take) begin
			r_next.display_area_change = 1'b0;
			r_next.swap_p = 1'b1;
		end
		if (start_take) begin
			r_next.rendering_start = 1'b0;
			r_next.start_p = 1'b1;
		end
		if (fifo_empty) begin
			r_next.flush = 1'b0;
		end

		// interrupt status: write one to clear, before hardware sets
		if (access_done & pwrite & (paddr == `RBC_ISTAT_OFF)) begin
			r_next.istat = r_reg.istat & ~pwdata[`RBC_IRQ_W-1:0];
		end
		if (access_done & pwrite & (paddr == `RBC_IMASK_OFF)) begin
			r_next.imask = pwdata[`RBC_IRQ_W-1:0];
		end

		// host writes: zeros never clear the self-clearing bits
		if (sys_wr) begin
			r_next.display_reset = pwdata[`RBC_DISPLAY_RESET_BIT];
			r_next.display_enable = pwdata[`RBC_DEN_BIT];
			if (pwdata[`RBC_RENDERING_BREAK_REQUEST_BIT]) begin
				r_next.rendering_break_request = 1'b1;
			end
			if (pwdata[`RBC_DC_BIT] & ~r_reg.display_area_change) begin
				r_next.display_area_change = 1'b1;
			end
			if (pwdata[`RBC_RS_BIT]) begin
				r_next.rendering_start = 1'b1;
				r_next.flush = 1'b1;
			end
			// the prohibited code is dropped, keeping the old mode
			if (pwdata[`RBC_DBM_HI:`RBC_DBM_LO] != RBC_DBM_BAD) begin
				r_next.dbm = rbc_dbm_e'(pwdata[`RBC_DBM_HI:`RBC_DBM_LO]);
			end
		end

		// drain requests from idle gaps and host reads
		if (idle_hit) begin
			r_next.flush = 1'b1;
		end
		if (host_gm_read) begin
			r_next.flush = 1'b1;
		end

		// engine events set flags last, so they win over clears
		if (trap_exec) begin
			r_next.trap_flag = 1'b1;
			r_next.term_p = 1'b1;
			r_next.istat[`RBC_IRQ_TRAP] = 1'b1;
		end
		// flag only sets on a fetch during drawing
		if (brk_take) begin
			r_next.drawing_break_flag = 1'b1;
			r_next.term_p = 1'b1;
			r_next.command_status_register = cmd_fetch_addr;
			r_next.istat[`RBC_IRQ_BRK] = 1'b1;
		end
		if (cmd_error_ev) begin
			r_next.cmd_error = 1'b1;
			r_next.istat[`RBC_IRQ_CER] = 1'b1;
		end
		if (cmd_suspend_ev) begin
			r_next.cmd_suspend = 1'b1;
		end
		if (swap_take) begin
			r_next.istat[`RBC_IRQ_SWAP] = 1'b1;
		end
		if (start_take) begin
			r_next.istat[`RBC_IRQ_START] = 1'b1;
		end

		r_next.irq = |(r_next.istat & r_next.imask);
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_reg <= '0;
			r_reg.display_reset <= `RBC_DISPLAY_RESET_RST;
			r_reg.dbm <= rbc_dbm_e'(`RBC_DBM_RST);
		end else begin
			r_reg <= r_next;
		end
	end

	// outputs straight from the state flops
	assign prdata = r_reg.rdata;
	assign pready = r_reg.ready;
	assign pslverr = r_reg.slverr;
	assign fifo_flush = r_reg.flush;
	assign render_start = r_reg.start_p;
	assign draw_terminate = r_reg.term_p;
	assign buffer_switch = r_reg.swap_p;
	assign dbm_mode = r_reg.dbm;
	assign display_reset = r_reg.display_reset;
	assign display_enable = r_reg.display_enable;
	assign irq = r_reg.irq;

	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_trap;
		trap_exec |=> r_reg.trap_flag && r_reg.term_p;
	endproperty
	a_trap: assert property (p_trap) else $error("trap did not end drawing");

	property p_brk;
		brk_take |=> r_reg.drawing_break_flag && r_reg.term_p && !r_reg.rendering_break_request;
	endproperty
	a_brk: assert property (p_brk) else $error("break not taken at fetch");

	property p_brk_idle;
		!drawing_active |=> !$rose(r_reg.drawing_break_flag);
	endproperty
	a_brk_idle: assert property (p_brk_idle) else $error("break flag set while idle");

	property p_command_status_register;
		brk_take |=> r_reg.command_status_register == $past(cmd_fetch_addr);
	endproperty
	a_command_status_register: assert property (p_command_status_register) else $error("command status not loaded");

	property p_rendering_break_request_clr;
		$fell(r_reg.rendering_break_request) |-> $past(brk_take) || $past(software_reset_wr);
	endproperty
	a_rendering_break_request_clr: assert property (p_rendering_break_request_clr) else $error("break request cleared early");

	property p_swap;
		swap_take |=> r_reg.swap_p && !r_reg.display_area_change;
	endproperty
	a_swap: assert property (p_swap) else $error("swap not done");

	property p_swap_cause;
		r_reg.swap_p |-> $past(r_reg.dbm) == RBC_DBM_MANUAL && $past(r_reg.display_area_change);
	endproperty
	a_swap_cause: assert property (p_swap_cause) else $error("swap without request");

	property p_dc_hold;
		r_reg.display_area_change && !swap_take |=> r_reg.display_area_change;
	endproperty
	a_dc_hold: assert property (p_dc_hold) else $error("display change lost");

	property p_start;
		r_reg.start_p |-> !r_reg.rendering_start && $past(fifo_empty) && !$past(refresh_only);
	endproperty
	a_start: assert property (p_start) else $error("bad rendering start");

	property p_rs_flush;
		(sys_wr && pwdata[`RBC_RS_BIT]) |=> r_reg.flush ##1 !r_reg.start_p;
	endproperty
	a_rs_flush: assert property (p_rs_flush) else $error("start before drain");

	property p_idle;
		idle_hit |=> r_reg.flush;
	endproperty
	a_idle: assert property (p_idle) else $error("idle drain missing");

	property p_read;
		host_gm_read |=> r_reg.flush;
	endproperty
	a_read: assert property (p_read) else $error("read drain missing");

	property p_dbm;
		(sys_wr && pwdata[`RBC_DBM_HI:`RBC_DBM_LO] == 2'b11) |=> r_reg.dbm == $past(r_reg.dbm);
	endproperty
	a_dbm: assert property (p_dbm) else $error("prohibited mode taken");

	property p_software_reset;
		software_reset_wr && !trap_exec && !brk_take |=> !r_reg.trap_flag && !r_reg.drawing_break_flag;
	endproperty
	a_software_reset: assert property (p_software_reset) else $error("software reset missed flags");

	c_brk: cover property (brk_take ##1 r_reg.term_p);
	c_swap: cover property (swap_take);
	c_start: cover property (sys_wr && pwdata[`RBC_RS_BIT] ##[1:40] r_reg.start_p);
	c_idle: cover property (idle_hit ##1 r_reg.flush);
endmodule : rbc_top

// ---- bench/rbc_engine_model.sv ----
// behavioural rendering engine and host write fifo on the far side
// assumes all signals on pclk; outputs move by nba just after the edge
`timescale 1ns/1ps
module rbc_engine_model (
	input wire logic pclk, // system clock
	input wire logic presetn, // async reset, active low
	input wire logic render_start, // start pulse from block
	input wire logic draw_terminate, // end pulse from block
	input wire logic fifo_flush, // drain request from block
	input wire logic host_wr, // host wrote graphics memory
	output logic drawing_active, // engine drawing
	output logic cmd_fetch, // command fetch pulse
	output logic [31:0] cmd_fetch_addr, // fetch address
	output logic fifo_empty // host write fifo empty
);
	logic [1:0] phase;
	logic [3:0] drain;
	// fetch every fourth cycle, idle too, so a break request while idle is tried
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drawing_active <= 1'b0;
			cmd_fetch <= 1'b0;
			cmd_fetch_addr <= 32'h0;
			phase <= 2'h0;
			fifo_empty <= 1'b1;
			drain <= 4'h0;
		end else begin
			cmd_fetch_addr <= cmd_fetch_addr + 32'h4;
			phase <= phase + 2'h1;
			cmd_fetch <= phase == 2'h3;
			if (render_start) begin
				drawing_active <= 1'b1;
			end else if (draw_terminate) begin
				drawing_active <= 1'b0;
			end
			// slow drain: four cycles of memory writes per flush
			if (host_wr) begin
				fifo_empty <= 1'b0;
			end else if (drain == 4'h3) begin
				fifo_empty <= 1'b1;
			end
			drain <= (fifo_flush && !fifo_empty) ? drain + 4'h1 : 4'h0;
		end
	end
endmodule : rbc_engine_model

// ---- bench/tb.sv ----
// self-checking bench for the rendering break and buffer control block
// assumes rbc_pkg, rbc_top and the engine model are compiled before it
`timescale 1ns/1ps
`include "rbc_defines.svh"
module tb;
	import rbc_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, hit;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, fetch_addr, cmd_fetch_addr;
	logic drawing_active, cmd_fetch, fifo_empty, fifo_flush, render_start;
	logic draw_terminate, buffer_switch, display_reset, display_enable, irq;
	logic trap_exec, frame_start, field_start, host_gm_access, host_gm_read;
	logic ilace_sync_video;
	logic cmd_error_ev, cmd_suspend_ev;
	logic [4:0] ev;
	logic [3:0] obs;
	rbc_dbm_e dbm_mode;
	int bad_count = 0;
	int compares = 0;
	int seed;
	localparam logic [31:0] RUN = 32'h2000; // display running, not refresh only
	assign {trap_exec, frame_start, field_start, host_gm_access, host_gm_read} = ev;
	assign obs = {render_start, draw_terminate, buffer_switch, fifo_flush};
	rbc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .drawing_active(drawing_active), .cmd_fetch(cmd_fetch),
		.cmd_fetch_addr(cmd_fetch_addr), .trap_exec(trap_exec), .cmd_error_ev(cmd_error_ev),
		.cmd_suspend_ev(cmd_suspend_ev), .frame_start(frame_start), .field_start(field_start),
		.ilace_sync_video(ilace_sync_video), .host_gm_access(host_gm_access),
		.host_gm_read(host_gm_read), .fifo_empty(fifo_empty), .fifo_flush(fifo_flush),
		.render_start(render_start), .draw_terminate(draw_terminate),
		.buffer_switch(buffer_switch), .dbm_mode(dbm_mode), .display_reset(display_reset),
		.display_enable(display_enable), .irq(irq));
	rbc_engine_model model (.pclk(pclk), .presetn(presetn), .render_start(render_start),
		.draw_terminate(draw_terminate), .fifo_flush(fifo_flush), .host_wr(host_gm_access),
		.drawing_active(drawing_active), .cmd_fetch(cmd_fetch),
		.cmd_fetch_addr(cmd_fetch_addr), .fifo_empty(fifo_empty));
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// last fetch address seen, the one a break must report
	always @(posedge pclk) begin
		if (cmd_fetch && drawing_active) begin
			fetch_addr <= cmd_fetch_addr;
		end
	end
	task automatic stop_test;
		if (bad_count == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask : chk
	// request held until the rising edge that samples pready high; data taken there
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic pulse(input logic [4:0] v);
		@(posedge pclk);
		ev <= v;
		@(posedge pclk);
		ev <= 5'h0;
	endtask : pulse
	// pulses are seen at negedges, away from the launching edge
	task automatic waitp(input int i, input int lim);
		hit = 1'b0;
		repeat (lim) begin
			@(negedge pclk);
			if (obs[i] === 1'b1) begin
				hit = 1'b1;
				break;
			end
		end
	endtask : waitp
	initial begin
		#(50 * 5000);
		bad_count++;
		stop_test();
	end
	initial begin
		seed = 95970;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		ev = 5'h0;
		cmd_error_ev = 1'b0;
		cmd_suspend_ev = 1'b0;
		ilace_sync_video = 1'b0;
		presetn = 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, `RBC_SYSCTL_OFF, 0);
		chk(rd, 32'h4000, "sysctl reset value");
		chk({display_reset, dbm_mode}, 3'h4, "reset outputs");
		apb(0, 8'h3c, 0);
		chk(err, 1, "unmapped read error");
		chk(rd, 0, "unmapped read data");
		// every mode value; the prohibited one must leave 10 in place
		for (int m = 0; m < 4; m++) begin
			apb(1, `RBC_SYSCTL_OFF, 32'h4000 | (m << 6));
			apb(0, `RBC_SYSCTL_OFF, 0);
			chk({rd[7:6], dbm_mode}, (m == 3) ? 4'ha : {2{m[1:0]}}, "buffer mode");
		end
		apb(1, `RBC_SYSCTL_OFF, 32'h4400);
		repeat (6) @(posedge pclk);
		apb(0, `RBC_STAT_OFF, 0);
		chk(rd[1], 0, "break flag while idle");
		pulse(5'h02);
		apb(1, `RBC_SYSCTL_OFF, 32'h4500);
		waitp(3, 30);
		chk(hit, 0, "start in refresh only");
		chk(fifo_empty, 1, "fifo drained on start");
		apb(0, `RBC_SYSCTL_OFF, 0);
		chk(rd[10:8], 3'h5, "break and start pending");
		apb(1, `RBC_SYSCTL_OFF, RUN | 32'h400);
		waitp(3, 20);
		chk({hit, fifo_empty}, 2'h3, "start after fifo drain");
		chk({display_reset, display_enable}, 2'h1, "display control outputs");
		// watch for the break first: a register read here could hide its pulse
		waitp(2, 20);
		chk(hit, 1, "break ends drawing");
		apb(0, `RBC_SYSCTL_OFF, 0);
		chk(rd[8], 0, "start bit self clears");
		apb(0, `RBC_STAT_OFF, 0);
		chk(rd[1], 1, "break flag set");
		apb(0, `RBC_COMMAND_STATUS_REGISTER_OFF, 0);
		chk(rd, fetch_addr, "next command address");
		apb(0, `RBC_SYSCTL_OFF, 0);
		chk(rd[10], 0, "break request cleared");
		// interrupt masked, unmasked, then cleared
		apb(1, `RBC_IMASK_OFF, 0);
		@(negedge pclk);
		chk(irq, 0, "masked interrupt");
		apb(1, `RBC_IMASK_OFF, 32'h2);
		repeat (2) @(posedge pclk);
		chk(irq, 1, "unmasked interrupt");
		apb(1, `RBC_ISTAT_OFF, 32'h2);
		repeat (2) @(posedge pclk);
		chk(irq, 0, "interrupt cleared");
		pulse(5'h10);
		waitp(2, 3);
		chk(hit, 1, "trap ends drawing");
		// engine error and suspend flags, for the software reset below
		@(posedge pclk);
		cmd_error_ev <= 1'b1;
		cmd_suspend_ev <= 1'b1;
		@(posedge pclk);
		cmd_error_ev <= 1'b0;
		cmd_suspend_ev <= 1'b0;
		apb(0, `RBC_STAT_OFF, 0);
		chk(rd[1:0], 2'h3, "trap flag set");
		chk(rd[3:2], 2'h3, "engine error flags set");
		apb(1, `RBC_SYSCTL_OFF, RUN | 32'h8000);
		apb(0, `RBC_STAT_OFF, 0);
		chk(rd[3:0], 4'h0, "software reset flags");
		// manual swaps: field edges count only in sync and video
		for (int s = 0; s < 2; s++) begin
			ilace_sync_video <= s[0];
			apb(1, `RBC_SYSCTL_OFF, RUN | 32'h280);
			repeat (1 + ($unsigned($random(seed)) % 8)) @(posedge pclk);
			pulse(s ? 5'h08 : 5'h04);
			waitp(1, 4);
			chk(hit, 0, "swap on wrong boundary");
			apb(0, `RBC_SYSCTL_OFF, 0);
			chk(rd[9], 1, "swap request held");
			pulse(s ? 5'h04 : 5'h08);
			waitp(1, 3);
			chk(hit, 1, "swap on boundary");
			apb(0, `RBC_SYSCTL_OFF, 0);
			chk(rd[9], 0, "swap request cleared");
		end
		// short random gaps keep the fifo from draining
		repeat (40) @(posedge pclk);
		for (int g = 0; g < 5; g++) begin
			pulse(5'h02);
			waitp(0, 2 + ($unsigned($random(seed)) % 24));
			chk(hit, 0, "drain inside short gap");
		end
		pulse(5'h02);
		waitp(0, 28);
		chk(hit, 0, "drain before idle time");
		waitp(0, 12);
		chk(hit, 1, "drain after idle time");
		// let that drain finish so the read drain below stands alone
		repeat (20) @(negedge pclk);
		chk(fifo_flush, 0, "drain ends once fifo empty");
		pulse(5'h02);
		pulse(5'h03);
		waitp(0, 3);
		chk(hit, 1, "drain on host read");
		stop_test();
	end
endmodule : tb
